// ---- src/mic_gain_cfg.svh ----
// constants of the microphone gain stage control: offsets, fields, resets, timing
// assumes it is included by bare name from the package and the design module
// Notes on behaviour
// - two-bit bias code picks microphone bias level
// - seven-bit gain code, 0.5 dB per step
// - gain changes move gradually by soft-stepping
// - reset gives 0 dB gain, soft-stepping enabled
// - two-bit field in power register controls soft-step
// - soft-step ticks come from internal divider
// - resistance code 01 adds 6 dB, 1x subtracts
// - same scaling for both auxiliary inputs
// - one bit selects automatic gain loop
// - without automatic loop, fixed code is target
// - status bit set when applied equals target
// - preamp disabled forces applied gain to 0 dB
// - mute holds the digital output word
// - power flag readable, held until ramp ends
`ifndef MIC_GAIN_CFG_SVH
`define MIC_GAIN_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_STATUS     8'h24
`define OFS_BIAS       8'h2e
`define OFS_GAIN       8'h2f
`define OFS_RIN        8'h30
`define OFS_PWR        8'h51
`define OFS_MUTE       8'h52
`define OFS_AGC        8'h56

// ****************************************
// field positions and reset values
// ****************************************
`define BIT_REACHED    7
`define BIT_PWR_FLAG   6
`define BIT_PWR_UP     7
`define BIT_PREAMP_DIS 7
`define BIT_MUTE       7
`define BIT_AGC_EN     7
`define RST_BIAS       8'h00
`define RST_GAIN       8'h80
`define RST_RIN        8'h00
`define RST_PWR        8'h00
`define RST_MUTE       8'h00
`define RST_AGC        8'h00
`define SOFTSTEP_ON    2'h0
`define GAIN_MAX       7'h77
`define GAIN_SIX_DB    9'h00c

// ****************************************
// timing: soft-step tick period
// ****************************************
`define CLK_NS         40
`define STEP_TICK_NS   1000000
`define STEP_TICK_CYC  (`STEP_TICK_NS / `CLK_NS)

`endif

// ---- src/mic_gain_pkg.sv ----
// types of the microphone gain stage control
// assumes the constants header sits beside it
package mic_gain_pkg;
	`include "mic_gain_cfg.svh"

	// converter power sequence
	typedef enum logic [1:0] {
		PWR_OFF,
		PWR_ON,
		PWR_RAMP_DOWN
	} pwr_state_t;

	// effective gain in signed half-dB codes
	typedef logic signed [8:0] eff_gain_t;
endpackage

// ---- src/mic_gain_stage_control.sv ----
// microphone gain stage control: registers, soft-stepped preamp gain, mute hold
// assumes register port strobes and converter words are synchronous to clk_i
`timescale 1ns/1ps
`include "mic_gain_cfg.svh"
module mic_gain_stage_control
	import mic_gain_pkg::*;
#(
	parameter int STEP_DIV = `STEP_TICK_CYC
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	// register port
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	input  wire logic [7:0]       reg_wdata_i,
	output logic      [7:0]       reg_rdata_o,
	// automatic gain loop and converter data
	input  wire logic [6:0]       agc_gain_i,
	input  wire logic [15:0]      adc_word_i,
	input  wire logic             adc_valid_i,
	output logic      [15:0]      adc_word_o,
	// analog controls
	output logic      [1:0]       mic_bias_level_o,
	output logic      [6:0]       mic_preamp_gain_o,
	output logic                  adc_power_flag_o,
	output eff_gain_t             mic_eff_gain_o,
	output eff_gain_t             auxiliary_input_one_gain_o,
	output eff_gain_t             auxiliary_input_two_gain_o
);

	// elaboration check on the divider
	if (STEP_DIV < 1) begin : g_chk
		$error("STEP_DIV must be at least one");
	end

	// ****************************************
	// register file
	// ****************************************
	logic [7:0] bias_r, bias_nxt;
	logic [7:0] gain_r, gain_nxt;
	logic [7:0] rin_r, rin_nxt;
	logic [7:0] pwr_r, pwr_nxt;
	logic [7:0] mute_r, mute_nxt;
	logic [7:0] agc_r, agc_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic       reached_r;

	// software writes; the status register is read-only
	always_comb begin
		bias_nxt = bias_r;
		gain_nxt = gain_r;
		rin_nxt  = rin_r;
		pwr_nxt  = pwr_r;
		mute_nxt = mute_r;
		agc_nxt  = agc_r;
		if (reg_wr_i) begin
			if (reg_addr_i == `OFS_BIAS) begin
				bias_nxt = reg_wdata_i;
			end else if (reg_addr_i == `OFS_GAIN) begin
				gain_nxt = reg_wdata_i;
			end else if (reg_addr_i == `OFS_RIN) begin
				rin_nxt = reg_wdata_i;
			end else if (reg_addr_i == `OFS_PWR) begin
				pwr_nxt = reg_wdata_i;
			end else if (reg_addr_i == `OFS_MUTE) begin
				mute_nxt = reg_wdata_i;
			end else if (reg_addr_i == `OFS_AGC) begin
				agc_nxt = reg_wdata_i;
			end
		end
	end

	// read data is captured on the read strobe; unmapped reads give zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_i) begin
			if (reg_addr_i == `OFS_STATUS) begin
				rdata_nxt = {reached_r, adc_power_flag_o, 6'h00};
			end else if (reg_addr_i == `OFS_BIAS) begin
				rdata_nxt = bias_r;
			end else if (reg_addr_i == `OFS_GAIN) begin
				rdata_nxt = gain_r;
			end else if (reg_addr_i == `OFS_RIN) begin
				rdata_nxt = rin_r;
			end else if (reg_addr_i == `OFS_PWR) begin
				rdata_nxt = pwr_r;
			end else if (reg_addr_i == `OFS_MUTE) begin
				rdata_nxt = mute_r;
			end else if (reg_addr_i == `OFS_AGC) begin
				rdata_nxt = agc_r;
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bias_r  <= `RST_BIAS;
			gain_r  <= `RST_GAIN;
			rin_r   <= `RST_RIN;
			pwr_r   <= `RST_PWR;
			mute_r  <= `RST_MUTE;
			agc_r   <= `RST_AGC;
			rdata_r <= 8'h00;
		end else begin
			bias_r  <= bias_nxt;
			gain_r  <= gain_nxt;
			rin_r   <= rin_nxt;
			pwr_r   <= pwr_nxt;
			mute_r  <= mute_nxt;
			agc_r   <= agc_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ****************************************
	// soft-step tick divider
	// ****************************************
	logic [31:0] div_r, div_nxt;
	logic        tick;

	// free-running on clk_i, so soft-step ticks come only while that clock runs
	always_comb begin
		tick    = (div_r == 32'(STEP_DIV - 1));
		div_nxt = tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_r <= 32'h0000_0000;
		end else begin
			div_r <= div_nxt;
		end
	end

	// ****************************************
	// gain target, soft-step and power sequence
	// ****************************************
	pwr_state_t st_r, st_nxt;
	logic [6:0] applied_r, applied_nxt;
	logic [6:0] target, code;
	logic       soft_en, preamp_en, reached_nxt;
	logic       flag_r, flag_nxt;

	always_comb begin
		soft_en   = (pwr_r[1:0] == `SOFTSTEP_ON);
		preamp_en = !gain_r[`BIT_PREAMP_DIS];
		code      = agc_r[`BIT_AGC_EN] ? agc_gain_i : gain_r[6:0];
		if (code > `GAIN_MAX) begin
			code = `GAIN_MAX;
		end
		target = (st_r == PWR_ON) ? code : 7'h00;
		// power sequence: ramp to 0 dB before the flag clears
		st_nxt = st_r;
		case (st_r)
			PWR_OFF: begin
				if (pwr_r[`BIT_PWR_UP]) begin
					st_nxt = PWR_ON;
				end
			end
			PWR_ON: begin
				if (!pwr_r[`BIT_PWR_UP]) begin
					st_nxt = PWR_RAMP_DOWN;
				end
			end
			default: begin
				if (pwr_r[`BIT_PWR_UP]) begin
					st_nxt = PWR_ON;
				end else if (applied_r == 7'h00) begin
					st_nxt = PWR_OFF;
				end
			end
		endcase
		// applied gain follows the target
		applied_nxt = applied_r;
		if (!preamp_en) begin
			applied_nxt = 7'h00;
		end else if (!soft_en) begin
			applied_nxt = target;
		end else if (tick && applied_r < target) begin
			applied_nxt = applied_r + 7'h01;
		end else if (tick && applied_r > target) begin
			applied_nxt = applied_r - 7'h01;
		end
		reached_nxt = (applied_r == target);
		// registered from the next state so the flag leaves a flip-flop with no lag
		flag_nxt    = (st_nxt != PWR_OFF);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r      <= PWR_OFF;
			applied_r <= 7'h00;
			reached_r <= 1'b1;
			flag_r    <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			applied_r <= applied_nxt;
			reached_r <= reached_nxt;
			flag_r    <= flag_nxt;
		end
	end

	// ****************************************
	// effective gain per input and mute hold
	// ****************************************
	logic [15:0] word_r, word_nxt;
	logic        muted;

	// resistance field i sits at bits 7-6, 5-4, 3-2 for mic and both aux inputs
	for (genvar i = 0; i < 3; i++) begin : g_eff
		// each input keeps its own register, so no variable has two driving processes
		logic [1:0] sel;
		eff_gain_t  eff_r, eff_nxt;
		assign sel = rin_r[7 - 2 * i -: 2];
		always_comb begin
			eff_nxt = eff_gain_t'({2'b00, applied_r});
			if (sel == 2'b01) begin
				eff_nxt = eff_nxt + `GAIN_SIX_DB;
			end else if (sel[1]) begin
				eff_nxt = eff_nxt - `GAIN_SIX_DB;
			end
		end
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				eff_r <= 9'h000;
			end else begin
				eff_r <= eff_nxt;
			end
		end
	end

	// a muted converter holds its last word rather than zeroing it
	always_comb begin
		muted    = mute_r[`BIT_MUTE] || gain_r[`BIT_PREAMP_DIS];
		word_nxt = word_r;
		if (adc_valid_i && !muted) begin
			word_nxt = adc_word_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_r <= 16'h0000;
		end else begin
			word_r <= word_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// the codec clock may stop only once this flag drops
	assign reg_rdata_o                = rdata_r;
	assign adc_word_o                 = word_r;
	assign mic_bias_level_o           = bias_r[1:0];
	assign mic_preamp_gain_o          = applied_r;
	assign adc_power_flag_o           = flag_r;
	assign mic_eff_gain_o             = g_eff[0].eff_r;
	assign auxiliary_input_one_gain_o = g_eff[1].eff_r;
	assign auxiliary_input_two_gain_o = g_eff[2].eff_r;

	// ****************************************
	// assertions
	// ****************************************
	property p_bias;
		@(posedge clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == `OFS_BIAS |=> mic_bias_level_o == $past(reg_wdata_i[1:0]);
	endproperty
	a_bias: assert property (p_bias) else $error("bias level not taken");

	property p_max;
		@(posedge clk_i) disable iff (!rst_b_i)
		mic_preamp_gain_o <= `GAIN_MAX;
	endproperty
	a_max: assert property (p_max) else $error("gain above top code");

	property p_hold;
		@(posedge clk_i) disable iff (!rst_b_i)
		soft_en && preamp_en && !tick |=> $stable(mic_preamp_gain_o);
	endproperty
	a_hold: assert property (p_hold) else $error("gain moved without tick");

	property p_step;
		@(posedge clk_i) disable iff (!rst_b_i)
		soft_en && preamp_en && tick && applied_r < target |=> applied_r == $past(applied_r) + 7'h01;
	endproperty
	a_step: assert property (p_step) else $error("step not one code");

	property p_dis;
		@(posedge clk_i) disable iff (!rst_b_i)
		!preamp_en |=> mic_preamp_gain_o == 7'h00;
	endproperty
	a_dis: assert property (p_dis) else $error("disabled preamp not 0 dB");

	property p_reach;
		@(posedge clk_i) disable iff (!rst_b_i)
		1'b1 |=> reached_r == ($past(applied_r) == $past(target));
	endproperty
	a_reach: assert property (p_reach) else $error("reached flag wrong");

	property p_mute;
		@(posedge clk_i) disable iff (!rst_b_i)
		muted |=> $stable(adc_word_o);
	endproperty
	a_mute: assert property (p_mute) else $error("muted word changed");

	property p_flag;
		@(posedge clk_i) disable iff (!rst_b_i)
		st_r == PWR_RAMP_DOWN && applied_r != 7'h00 |=> adc_power_flag_o;
	endproperty
	a_flag: assert property (p_flag) else $error("flag dropped before ramp end");

	property p_fixed;
		@(posedge clk_i) disable iff (!rst_b_i)
		st_r == PWR_ON && !agc_r[`BIT_AGC_EN] && gain_r[6:0] <= `GAIN_MAX |-> target == gain_r[6:0];
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed code not target");

	property p_jump;
		@(posedge clk_i) disable iff (!rst_b_i)
		!soft_en && preamp_en |=> mic_preamp_gain_o == $past(target);
	endproperty
	a_jump: assert property (p_jump) else $error("unstepped gain not at target");

	property p_plus;
		@(posedge clk_i) disable iff (!rst_b_i)
		rin_r[7:6] == 2'b01 |=> mic_eff_gain_o == eff_gain_t'({2'b00, $past(applied_r)}) + `GAIN_SIX_DB;
	endproperty
	a_plus: assert property (p_plus) else $error("mic gain not raised by 6 dB");

	property p_minus;
		@(posedge clk_i) disable iff (!rst_b_i)
		rin_r[3] |=> auxiliary_input_two_gain_o == eff_gain_t'({2'b00, $past(applied_r)}) - `GAIN_SIX_DB;
	endproperty
	a_minus: assert property (p_minus) else $error("aux two gain not lowered by 6 dB");

	c_ramp: cover property (@(posedge clk_i) disable iff (!rst_b_i) tick && applied_r < target ##1 reached_nxt);
	c_down: cover property (@(posedge clk_i) disable iff (!rst_b_i) st_r == PWR_RAMP_DOWN ##1 st_r == PWR_OFF);
	c_mute: cover property (@(posedge clk_i) disable iff (!rst_b_i) muted && adc_valid_i);
endmodule

// ---- dv/mic_front_model.sv ----
// analog front model: converter words and automatic loop gain code toward the block
// assumes clk_i and rst_b_i come from the bench; it drives on the falling edge
`timescale 1ns/1ps
module mic_front_model #(
	parameter logic [6:0] AGC_CODE = 7'h15
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// converter side
	output logic      [15:0] adc_word_o,
	output logic             adc_valid_o,
	output logic      [6:0]  agc_gain_o
);
	// ****************************************
	// sample stream
	// ****************************************
	// the word changes every sample so that a held output shows up
	always @(negedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			adc_word_o  <= 16'h0000;
			adc_valid_o <= 1'b0;
		end else begin
			adc_word_o  <= adc_word_o + 16'h0101;
			adc_valid_o <= ~adc_valid_o;
		end
	end
	// loop is taken as settled on one code; its algorithm is outside this block
	assign agc_gain_o = AGC_CODE;
endmodule

// ---- dv/mic_gain_stage_control_test.sv ----
// self-checking bench of the microphone gain stage control
// assumes the constants header is on the include path and the front model beside it
`timescale 1ns/1ps
`include "mic_gain_cfg.svh"
module mic_gain_stage_control_test;
	import mic_gain_pkg::*;
	// ****************************************
	// signals and instances
	// ****************************************
	localparam int STEP = 4;
	logic        clk_i;
	logic        rst_b;
	logic [7:0]  addr;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [6:0]  agc;
	logic [15:0] word_i;
	logic        valid;
	logic [15:0] word_o;
	logic [1:0]  bias;
	logic [6:0]  gain;
	logic        flag;
	eff_gain_t   eff_m;
	eff_gain_t   eff_a;
	eff_gain_t   eff_b;
	int          err_count;
	int          tests_run;
	int          n;
	logic [15:0] held;

	mic_gain_stage_control #(.STEP_DIV(STEP)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b), .reg_addr_i(addr),
		.reg_wr_i(wr_en), .reg_rd_i(rd_en), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .agc_gain_i(agc),
		.adc_word_i(word_i), .adc_valid_i(valid), .adc_word_o(word_o), .mic_bias_level_o(bias),
		.mic_preamp_gain_o(gain), .adc_power_flag_o(flag), .mic_eff_gain_o(eff_m),
		.auxiliary_input_one_gain_o(eff_a), .auxiliary_input_two_gain_o(eff_b));
	mic_front_model front_u (.clk_i(clk_i), .rst_b_i(rst_b), .adc_word_o(word_i), .adc_valid_o(valid),
		.agc_gain_o(agc));

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk_i);
		wr_en = 1'b0;
		@(negedge clk_i);
	endtask

	// rdata is registered at the read edge and holds, so a later negedge is safe
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_i);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk_i);
		rd_en = 1'b0;
		@(negedge clk_i);
		check("rdata", {8'h00, rdata}, {8'h00, exp});
	endtask

	// bounded wait for the applied gain; every cycle the move must be at most one code
	task automatic wait_gain(input logic [6:0] exp);
		logic [6:0] prev;
		prev = gain;
		n = 0;
		while (gain !== exp && n < 400) begin
			@(negedge clk_i);
			check("gain step", 16'(gain - prev <= 7'h01 || prev - gain <= 7'h01), 16'h0001);
			prev = gain;
			n++;
		end
		check("gain settled", {9'h000, gain}, {9'h000, exp});
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		err_count = 0;
		tests_run = 0;
		rst_b = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (12) @(negedge clk_i);
		rst_b = 1'b1;
		chk_rd(`OFS_GAIN, `RST_GAIN);
		chk_rd(`OFS_PWR, `RST_PWR);
		chk_rd(8'h77, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_BIAS, 8'(i));
			check("bias", {14'h0000, bias}, 16'(i));
		end
		wr(`OFS_PWR, 8'h80);
		check("power flag", {15'h0000, flag}, 16'h0001);
		wr(`OFS_GAIN, 8'h0a);
		wait_gain(7'h0a);
		check("ramp time", 16'(n >= 9 * STEP && n <= 11 * STEP + 2), 16'h0001);
		wr(`OFS_STATUS, 8'h00);
		chk_rd(`OFS_STATUS, 8'hc0);
		// mic, aux one and aux two fields all carry the same code
		for (int c = 0; c < 4; c++) begin
			wr(`OFS_RIN, {2'(c), 2'(c), 2'(c), 2'b00});
			n = (c == 0) ? 10 : (c == 1) ? 22 : -2;
			check("mic eff", 16'(eff_m), 16'($signed(9'(n))));
			check("aux one eff", 16'(eff_a), 16'($signed(9'(n))));
			check("aux two eff", 16'(eff_b), 16'($signed(9'(n))));
		end
		wr(`OFS_RIN, 8'h00);
		wr(`OFS_PWR, 8'h81);
		wr(`OFS_GAIN, 8'h77);
		check("gain jump", {9'h000, gain}, 16'h0077);
		wr(`OFS_AGC, 8'h80);
		check("loop gain", {9'h000, gain}, 16'h0015);
		wr(`OFS_AGC, 8'h00);
		check("fixed gain", {9'h000, gain}, 16'h0077);
		wr(`OFS_GAIN, 8'h7f);
		check("gain clamp", {9'h000, gain}, {9'h000, `GAIN_MAX});
		wr(`OFS_MUTE, 8'h80);
		held = word_o;
		repeat (6) @(negedge clk_i);
		check("muted word", word_o, held);
		wr(`OFS_MUTE, 8'h00);
		repeat (4) @(negedge clk_i);
		check("word moves", 16'(word_o !== held), 16'h0001);
		wr(`OFS_GAIN, 8'hf7);
		check("preamp off", {9'h000, gain}, 16'h0000);
		wr(`OFS_GAIN, 8'h08);
		// soft-step back on with power-down; the clock keeps running through the ramp
		wr(`OFS_PWR, 8'h00);
		check("flag in ramp", {15'h0000, flag}, 16'h0001);
		wait_gain(7'h00);
		repeat (2) @(negedge clk_i);
		check("flag cleared", {15'h0000, flag}, 16'h0000);
		// second reset in mid-run: registers and outputs go back to their reset state
		rst_b = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_b = 1'b1;
		check("bias after reset", {14'h0000, bias}, 16'(`RST_BIAS) & 16'h0003);
		chk_rd(`OFS_GAIN, `RST_GAIN);
		chk_rd(`OFS_STATUS, 8'h80);
		complete_run();
	end

	// watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#(40 * 20000);
		err_count++;
		complete_run();
	end
endmodule
